// file: rtl/dem_pkg.sv
// Constants and types shared by the event-to-channel map and its queues
package dem_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int unsigned DEM_NUM_CHAN = 64;
  localparam int unsigned DEM_NUM_QUEUE = 3;
  localparam int unsigned DEM_CHAN_W = 6;
  localparam int unsigned DEM_QSEL_W = 2;
  localparam int unsigned DEM_BURST_W = 8;

  // ----------------------------------------------------------------------
  // Default burst sizes in bytes after reset, one per transfer controller
  // ----------------------------------------------------------------------
  localparam logic [7:0] DEM_BURST_RST_ZERO = 8'h10;
  localparam logic [7:0] DEM_BURST_RST_ONE = 8'h20;
  localparam logic [7:0] DEM_BURST_RST_TWO = 8'h40;

  // ----------------------------------------------------------------------
  // Fixed channel numbers of the hardware event sources
  // ----------------------------------------------------------------------
  localparam int unsigned DEM_CH_BSP0_TX = 2;
  localparam int unsigned DEM_CH_BSP0_RX = 3;
  localparam int unsigned DEM_CH_BSP1_TX = 4;
  localparam int unsigned DEM_CH_BSP1_RX = 5;
  localparam int unsigned DEM_CH_VIDEO_BASE = 6;
  localparam int unsigned DEM_CH_AUDIO_TX_BASE = 10;
  localparam int unsigned DEM_CH_AUDIO_RX_BASE = 13;
  localparam int unsigned DEM_CH_UART0_RX = 22;
  localparam int unsigned DEM_CH_UART0_TX = 23;
  localparam int unsigned DEM_CH_UART1_RX = 24;
  localparam int unsigned DEM_CH_UART1_TX = 25;
  localparam int unsigned DEM_CH_TWOWIRE_RX = 28;
  localparam int unsigned DEM_CH_TWOWIRE_TX = 29;
  localparam int unsigned DEM_CH_PIN_BASE = 32;
  localparam int unsigned DEM_CH_BANK_BASE = 40;
  localparam int unsigned DEM_CH_TIMER_BASE = 48;
  localparam int unsigned DEM_CH_PULSE_BASE = 52;
  localparam int unsigned DEM_NUM_PIN = 8;
  localparam int unsigned DEM_NUM_BANK = 7;

  // ----------------------------------------------------------------------
  // Queue slot state, Gray coded
  // ----------------------------------------------------------------------
  typedef enum logic [0:0] {
    DEM_Q_IDLE = 1'b0,
    DEM_Q_OFFER = 1'b1
  } dem_qstate_t;

  // ----------------------------------------------------------------------
  // Whole state of the block
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [63:0] pending;
    logic [2:0][7:0] burst;
    dem_qstate_t [2:0] qstate;
    logic [2:0][5:0] qchan;
    logic compl_global;
    logic compl_region0;
    logic compl_region1;
    logic [2:0] tc_error;
    logic cc_error;
  } dem_state_t;

endpackage

// file: rtl/dem_event_map.sv
// Event-to-channel map, pending latch, queue submission and interrupts
//
// Overview of operation
// - There are 64 channels, each triggered and serviced on its own.
// - Three queues exist, each feeding its own transfer controller.
// - Each controller has a burst size software may load; reset gives 16, 32 and 64 bytes.
// - Three completion interrupts: global, shadow region zero and shadow region one.
// - Four error interrupts: global channel-controller error and one per transfer controller.
// - Each listed channel has one fixed event source; software enables which events trigger.
// - Channels 2..5 take the transmit and receive events of serial ports zero and one.
// - Channels 6..9 take histogram, statistics, previewer and resizer video events.
// - Channels 10..15 take the audio transmit-even/odd/plain and receive-even/odd/plain events.
// - Channels 22..25 take the receive and transmit events of UART zero then UART one.
// - Channels 28 and 29 take the two-wire receive and transmit events.
// - Channels 32..39 take pin interrupts zero to seven in order.
// - Channels 40..46 take pin bank interrupts zero to six in order.
// - Channels 48..51 take timer zero low/high then timer one low/high events.
// - Channels 52..54 take pulse modulator events zero to two.
`timescale 1ns/100ps

module dem_event_map (
  input wire logic clock_in, // System clock, 250 MHz
  input wire logic resetn_in, // Async reset, active low
  input wire logic bsp0_tx_event_in, // Serial port 0 transmit
  input wire logic bsp0_rx_event_in, // Serial port 0 receive
  input wire logic bsp1_tx_event_in, // Serial port 1 transmit
  input wire logic bsp1_rx_event_in, // Serial port 1 receive
  input wire logic video_histogram_event_in, // Video histogram
  input wire logic video_statistics_event_in, // Video statistics
  input wire logic video_previewer_event_in, // Video previewer
  input wire logic video_resizer_event_in, // Video resizer
  input wire logic audio_tx_even_event_in, // Audio transmit even
  input wire logic audio_tx_odd_event_in, // Audio transmit odd
  input wire logic audio_tx_event_in, // Audio transmit
  input wire logic audio_rx_even_event_in, // Audio receive even
  input wire logic audio_rx_odd_event_in, // Audio receive odd
  input wire logic audio_rx_event_in, // Audio receive
  input wire logic uart0_rx_event_in, // UART 0 receive
  input wire logic uart0_tx_event_in, // UART 0 transmit
  input wire logic uart1_rx_event_in, // UART 1 receive
  input wire logic uart1_tx_event_in, // UART 1 transmit
  input wire logic twowire_rx_event_in, // Two-wire receive
  input wire logic twowire_tx_event_in, // Two-wire transmit
  input wire logic [7:0] pin_interrupt_in, // Pin interrupts 0..7
  input wire logic [6:0] pin_bank_interrupt_in, // Pin bank interrupts 0..6
  input wire logic timer0_low_event_in, // Timer 0 low
  input wire logic timer0_high_event_in, // Timer 0 high
  input wire logic timer1_low_event_in, // Timer 1 low
  input wire logic timer1_high_event_in, // Timer 1 high
  input wire logic [2:0] pulse_mod_event_in, // Pulse modulators 0..2
  input wire logic [63:0] chan_enable_in, // Per-channel event enable
  input wire logic [127:0] chan_queue_in, // Two-bit queue pick per channel
  input wire logic [63:0] sw_trigger_in, // Software trigger pulses
  input wire logic [2:0] burst_load_in, // Load strobe per controller
  input wire logic [7:0] burst_value_in, // Burst size to load, bytes
  input wire logic [2:0] submit_ready_in, // Controller takes submission
  input wire logic [2:0] done_valid_in, // Controller finished a transfer
  input wire logic [17:0] done_chan_in, // Finished channel, 6 bits per controller
  input wire logic [2:0] tc_error_in, // Controller error pulse
  input wire logic [63:0] region0_mask_in, // Channels of shadow region 0
  input wire logic [63:0] region1_mask_in, // Channels of shadow region 1
  output logic [2:0] submit_valid_out, // Submission offered per queue
  output logic [17:0] submit_chan_out, // Channel offered, 6 bits per queue
  output logic [23:0] burst_size_out, // Burst size per controller, bytes
  output logic [63:0] pending_out, // Pending channel flags
  output logic compl_global_irq_out, // Completion, global
  output logic compl_region0_irq_out, // Completion, shadow region 0
  output logic compl_region1_irq_out, // Completion, shadow region 1
  output logic cc_error_irq_out, // Channel controller error
  output logic [2:0] tc_error_irq_out // Error per transfer controller
);
  import dem_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Fixed wiring of sources to channels; unlisted channels stay zero
  function automatic logic [63:0] map_events();
    logic [63:0] v;
    v = '0;
    v[DEM_CH_BSP0_TX] = bsp0_tx_event_in;
    v[DEM_CH_BSP0_RX] = bsp0_rx_event_in;
    v[DEM_CH_BSP1_TX] = bsp1_tx_event_in;
    v[DEM_CH_BSP1_RX] = bsp1_rx_event_in;
    v[DEM_CH_VIDEO_BASE] = video_histogram_event_in;
    v[DEM_CH_VIDEO_BASE + 1] = video_statistics_event_in;
    v[DEM_CH_VIDEO_BASE + 2] = video_previewer_event_in;
    v[DEM_CH_VIDEO_BASE + 3] = video_resizer_event_in;
    v[DEM_CH_AUDIO_TX_BASE] = audio_tx_even_event_in;
    v[DEM_CH_AUDIO_TX_BASE + 1] = audio_tx_odd_event_in;
    v[DEM_CH_AUDIO_TX_BASE + 2] = audio_tx_event_in;
    v[DEM_CH_AUDIO_RX_BASE] = audio_rx_even_event_in;
    v[DEM_CH_AUDIO_RX_BASE + 1] = audio_rx_odd_event_in;
    v[DEM_CH_AUDIO_RX_BASE + 2] = audio_rx_event_in;
    v[DEM_CH_UART0_RX] = uart0_rx_event_in;
    v[DEM_CH_UART0_TX] = uart0_tx_event_in;
    v[DEM_CH_UART1_RX] = uart1_rx_event_in;
    v[DEM_CH_UART1_TX] = uart1_tx_event_in;
    v[DEM_CH_TWOWIRE_RX] = twowire_rx_event_in;
    v[DEM_CH_TWOWIRE_TX] = twowire_tx_event_in;
    v[DEM_CH_PIN_BASE +: DEM_NUM_PIN] = pin_interrupt_in;
    v[DEM_CH_BANK_BASE +: DEM_NUM_BANK] = pin_bank_interrupt_in;
    v[DEM_CH_TIMER_BASE] = timer0_low_event_in;
    v[DEM_CH_TIMER_BASE + 1] = timer0_high_event_in;
    v[DEM_CH_TIMER_BASE + 2] = timer1_low_event_in;
    v[DEM_CH_TIMER_BASE + 3] = timer1_high_event_in;
    v[DEM_CH_PULSE_BASE +: 3] = pulse_mod_event_in;
    return v;
  endfunction

  // Queue of a channel; a pick of 3 is folded onto the last queue
  function automatic logic [1:0] queue_of(input int unsigned ch);
    logic [1:0] q;
    q = chan_queue_in[ch * DEM_QSEL_W +: DEM_QSEL_W];
    return (q > 2'h2) ? 2'h2 : q;
  endfunction

  // Lowest set bit: found flag and index
  function automatic logic [6:0] lowest_set(input logic [63:0] v);
    logic [6:0] r;
    r = '0;
    for (int i = DEM_NUM_CHAN - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 6'(i)};
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  dem_state_t state;
  dem_state_t next_state;
  logic [63:0] hw_event;
  logic [63:0] trigger;
  logic [63:0] taken;
  logic [6:0] pick;
  logic [63:0] qmask;
  logic [5:0] dch;

  // Next-state logic for pending flags, queue slots, burst sizes, interrupts
  always_comb begin
    next_state = state;
    hw_event = map_events();
    trigger = (hw_event & chan_enable_in) | sw_trigger_in;
    taken = '0;
    pick = '0;
    qmask = '0;
    dch = '0;
    // Each queue slot is independent and feeds its own controller
    for (int q = 0; q < DEM_NUM_QUEUE; q++) begin
      case (state.qstate[q])
        DEM_Q_IDLE: begin
          for (int c = 0; c < DEM_NUM_CHAN; c++) begin
            qmask[c] = state.pending[c] && (queue_of(c) == 2'(q));
          end
          pick = lowest_set(qmask);
          if (pick[6]) begin
            next_state.qstate[q] = DEM_Q_OFFER;
            next_state.qchan[q] = pick[5:0];
            taken[pick[5:0]] = 1'b1;
          end
        end
        DEM_Q_OFFER: begin
          if (submit_ready_in[q]) begin
            next_state.qstate[q] = DEM_Q_IDLE;
          end
        end
        default: begin
          next_state.qstate[q] = DEM_Q_IDLE;
        end
      endcase
    end
    // A new trigger in the cycle of submission keeps the flag set
    next_state.pending = (state.pending & ~taken) | trigger;
    // A trigger on a channel already pending and not taken this cycle is a missed event
    next_state.cc_error = |(trigger & state.pending & ~taken);
    // Burst sizes load from the shared value into every controller whose strobe is set
    for (int t = 0; t < DEM_NUM_QUEUE; t++) begin
      if (burst_load_in[t]) begin
        next_state.burst[t] = burst_value_in;
      end
    end
    // Completion pulses, routed by region membership of the channel
    next_state.compl_global = |done_valid_in;
    next_state.compl_region0 = 1'b0;
    next_state.compl_region1 = 1'b0;
    for (int t = 0; t < DEM_NUM_QUEUE; t++) begin
      dch = done_chan_in[t * DEM_CHAN_W +: DEM_CHAN_W];
      if (done_valid_in[t] && region0_mask_in[dch]) begin
        next_state.compl_region0 = 1'b1;
      end
      if (done_valid_in[t] && region1_mask_in[dch]) begin
        next_state.compl_region1 = 1'b1;
      end
    end
    next_state.tc_error = tc_error_in;
  end

  // State register; reset puts the default burst sizes in place
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= '0;
      state.burst[0] <= DEM_BURST_RST_ZERO;
      state.burst[1] <= DEM_BURST_RST_ONE;
      state.burst[2] <= DEM_BURST_RST_TWO;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------------------------------------
  always_comb begin
    for (int q = 0; q < DEM_NUM_QUEUE; q++) begin
      submit_valid_out[q] = (state.qstate[q] == DEM_Q_OFFER);
    end
  end

  assign submit_chan_out = state.qchan;
  assign burst_size_out = state.burst;
  assign pending_out = state.pending;
  assign compl_global_irq_out = state.compl_global;
  assign compl_region0_irq_out = state.compl_region0;
  assign compl_region1_irq_out = state.compl_region1;
  assign cc_error_irq_out = state.cc_error;
  assign tc_error_irq_out = state.tc_error;

endmodule

// file: tb/dem_monitor.sv
// Port checker for the event-to-channel map
`timescale 1ns/100ps
module dem_monitor (
  input wire logic clock_in, // Clock
  input wire logic resetn_in, // Reset
  input wire logic [7:0] pin_interrupt_in, // Pins
  input wire logic [63:0] chan_enable_in, // Enables
  input wire logic [63:0] sw_trigger_in, // Soft triggers
  input wire logic [2:0] burst_load_in, // Loads
  input wire logic [7:0] burst_value_in, // Load value
  input wire logic [2:0] submit_ready_in, // Ready
  input wire logic [2:0] done_valid_in, // Done
  input wire logic [2:0] tc_error_in, // Errors in
  input wire logic [2:0] submit_valid_out, // Offers
  input wire logic [17:0] submit_chan_out, // Offered channels
  input wire logic [23:0] burst_size_out, // Bursts
  input wire logic [63:0] pending_out, // Pending
  input wire logic compl_global_irq_out, // Completion
  input wire logic [2:0] tc_error_irq_out // Errors out
);
  // Channels with no hardware source
  localparam logic [63:0] RSV = ~64'h007f7fff_33c0fffc;
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!resetn_in);
  a_reserved_quiet: assert property (
    (pending_out & ~$past(pending_out) & RSV & ~$past(sw_trigger_in)) == 64'h0)
    else $error("reserved channel pended without software trigger");
  a_pin_map: assert property ($rose(pending_out[32]) |->
    $past(pin_interrupt_in[0] & chan_enable_in[32] | sw_trigger_in[32]))
    else $error("channel 32 pended without its cause");
  a_pin_trigger: assert property (
    pin_interrupt_in[0] && chan_enable_in[32] |=> pending_out[32])
    else $error("enabled pin event not latched");
  a_burst_load: assert property (
    burst_load_in[1] |=> burst_size_out[15:8] == $past(burst_value_in))
    else $error("burst load lost");
  a_offer_hold: assert property (
    submit_valid_out[0] && !submit_ready_in[0] |=>
    submit_valid_out[0] && $stable(submit_chan_out[5:0]))
    else $error("offer changed before acceptance");
  a_offer_drop: assert property (
    submit_valid_out[0] && submit_ready_in[0] |=> !submit_valid_out[0])
    else $error("offer stayed after acceptance");
  a_compl_pulse: assert property (
    compl_global_irq_out == $past(|done_valid_in))
    else $error("global completion pulse wrong");
  a_tc_error_copy: assert property (
    tc_error_irq_out == $past(tc_error_in))
    else $error("controller error pulse wrong");
  c_accept: cover property (submit_valid_out[0] && submit_ready_in[0]);
  c_stall: cover property (submit_valid_out[0] && !submit_ready_in[0]);
  c_done: cover property (compl_global_irq_out);
endmodule
bind dem_event_map dem_monitor dem_monitor_inst (.clock_in(clock_in), .resetn_in(resetn_in),
  .pin_interrupt_in(pin_interrupt_in), .chan_enable_in(chan_enable_in),
  .sw_trigger_in(sw_trigger_in), .burst_load_in(burst_load_in),
  .burst_value_in(burst_value_in), .submit_ready_in(submit_ready_in),
  .done_valid_in(done_valid_in), .tc_error_in(tc_error_in),
  .submit_valid_out(submit_valid_out), .submit_chan_out(submit_chan_out),
  .burst_size_out(burst_size_out), .pending_out(pending_out),
  .compl_global_irq_out(compl_global_irq_out), .tc_error_irq_out(tc_error_irq_out));

// file: tb/dem_partner.sv
// Transfer controller stand-in: takes offers, reports completion
`timescale 1ns/100ps
module dem_partner (
  input wire logic clock_in, // Clock
  input wire logic resetn_in, // Reset
  input wire logic [2:0] stall_in, // Hold off per queue
  input wire logic [2:0] fault_in, // Error request
  input wire logic [2:0] submit_valid_in, // Offers
  input wire logic [17:0] submit_chan_in, // Offered channels
  output logic [2:0] submit_ready_out, // Accept
  output logic [2:0] done_valid_out, // Completion
  output logic [17:0] done_chan_out, // Completed channel
  output logic [2:0] tc_error_out // Error pulse
);
  // Ready follows stall so a queue can be released at any edge
  assign submit_ready_out = ~stall_in;
  assign tc_error_out = fault_in;
  // Done one cycle after acceptance; channel lines invert when idle
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      done_valid_out <= 3'h0;
      done_chan_out <= 18'h0;
    end else begin
      done_valid_out <= submit_valid_in & ~stall_in;
      done_chan_out <= |(submit_valid_in & ~stall_in) ? submit_chan_in : ~done_chan_out;
    end
  end
endmodule

// file: tb/tb.sv
// Self-checking bench for the event-to-channel map
`timescale 1ns/100ps
module tb;
  logic clock_in, resetn_in, cg, c0, c1, cce;
  logic [63:0] ev, en, sw, r0, r1, pend;
  logic [127:0] qs;
  logic [2:0] bl, stall, err, rdy, dv, tce, sv, tci;
  logic [7:0] bv;
  logic [17:0] dc, sc;
  logic [23:0] bs, exp_bs;
  int errors, checks_done;
  localparam logic [63:0] MAPPED = 64'h007f7fff_33c0fffc;
  dem_event_map dem_event_map_inst (.clock_in(clock_in), .resetn_in(resetn_in),
    .bsp0_tx_event_in(ev[2]), .bsp0_rx_event_in(ev[3]), .bsp1_tx_event_in(ev[4]),
    .bsp1_rx_event_in(ev[5]), .video_histogram_event_in(ev[6]),
    .video_statistics_event_in(ev[7]), .video_previewer_event_in(ev[8]),
    .video_resizer_event_in(ev[9]), .audio_tx_even_event_in(ev[10]),
    .audio_tx_odd_event_in(ev[11]), .audio_tx_event_in(ev[12]),
    .audio_rx_even_event_in(ev[13]), .audio_rx_odd_event_in(ev[14]),
    .audio_rx_event_in(ev[15]), .uart0_rx_event_in(ev[22]), .uart0_tx_event_in(ev[23]),
    .uart1_rx_event_in(ev[24]), .uart1_tx_event_in(ev[25]), .twowire_rx_event_in(ev[28]),
    .twowire_tx_event_in(ev[29]), .pin_interrupt_in(ev[39:32]),
    .pin_bank_interrupt_in(ev[46:40]), .timer0_low_event_in(ev[48]),
    .timer0_high_event_in(ev[49]), .timer1_low_event_in(ev[50]),
    .timer1_high_event_in(ev[51]), .pulse_mod_event_in(ev[54:52]), .chan_enable_in(en),
    .chan_queue_in(qs), .sw_trigger_in(sw), .burst_load_in(bl), .burst_value_in(bv),
    .submit_ready_in(rdy), .done_valid_in(dv), .done_chan_in(dc), .tc_error_in(tce),
    .region0_mask_in(r0), .region1_mask_in(r1), .submit_valid_out(sv),
    .submit_chan_out(sc), .burst_size_out(bs), .pending_out(pend),
    .compl_global_irq_out(cg), .compl_region0_irq_out(c0), .compl_region1_irq_out(c1),
    .cc_error_irq_out(cce), .tc_error_irq_out(tci));
  dem_partner dem_partner_inst (.clock_in(clock_in), .resetn_in(resetn_in),
    .stall_in(stall), .fault_in(err), .submit_valid_in(sv), .submit_chan_in(sc),
    .submit_ready_out(rdy), .done_valid_out(dv), .done_chan_out(dc), .tc_error_out(tce));
  // Wide enough for the largest packed comparison, burst sizes plus pending flags
  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Inputs always change 1 ns after the edge
  task automatic step(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // One event cycle per channel must pend exactly that channel, or none
  task automatic t_map();
    for (int c = 0; c < 64; c++) begin
      ev[c] = 1'b1;
      step(1);
      ev[c] = 1'b0;
      check(pend, MAPPED[c] ? 64'h1 << c : 64'h0);
      step(3);
    end
    en = 64'h0;
    ev[40] = 1'b1;
    step(1);
    ev[40] = 1'b0;
    sw[63] = 1'b1;
    check(pend, 64'h0);
    step(1);
    sw = 64'h0;
    en = '1;
    check(pend, 64'h1 << 63);
  endtask
  // Stalled queue: lowest channel first, retrigger error, hold, release
  task automatic t_queue();
    step(4);
    stall = 3'b001;
    sw = 64'h28;
    step(1);
    sw = 64'h20;
    step(1);
    sw = 64'h0;
    check({sv, sc[5:0], pend}, {3'b001, 6'd3, 64'h20});
    check(cce, 1'b1);
    step(4);
    check({sv, sc[5:0]}, {3'b001, 6'd3});
    r0 = 64'h8;
    stall = 3'b000;
    step(1);
    check(sv[0], 1'b0);
    step(1);
    check({cg, c0, c1, sv[0], sc[5:0]}, {4'b1111, 6'd5});
    step(4);
    qs[15:14] = 2'b11;
    qs[17:16] = 2'b01;
    sw[7] = 1'b1;
    sw[8] = 1'b1;
    step(1);
    sw = 64'h0;
    step(1);
    check({sv, sc[17:6]}, {3'b110, 6'd7, 6'd8});
    step(4);
  endtask
  // Load each controller's burst size and watch only that one change
  task automatic t_burst();
    exp_bs = 24'h402010;
    for (int t = 0; t < 3; t++) begin
      bl = 3'b1 << t;
      bv = 8'hf0 + 8'(t);
      exp_bs[8*t+:8] = bv;
      step(1);
      bl = 3'b0;
      check(bs, exp_bs);
    end
  endtask
  // Each controller error gives a single pulse on its own output
  task automatic t_error();
    for (int t = 0; t < 3; t++) begin
      err = 3'b1 << t;
      step(1);
      err = 3'b0;
      check(tci, 3'b1 << t);
      step(1);
      check(tci, 3'h0);
    end
  endtask
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  initial begin
    resetn_in = 1'b0;
    {ev, sw, r0, qs, bl, bv, stall, err} = '0;
    en = '1;
    r1 = '1;
    errors = 0;
    checks_done = 0;
    step(12);
    check({bs, pend}, {24'h402010, 64'h0});
    resetn_in = 1'b1;
    t_map();
    t_queue();
    t_burst();
    t_error();
    conclude();
  end
endmodule
